/* File: hw/opmode_pkg.sv */
// shared constants and types for the operation mode selector
package opmode_pkg;
  localparam int NUM_TERM = 5;
  localparam int CODE_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SPD_W = 16;

  localparam logic [ADDR_W-1:0] REG_MODE_SEL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_POLARITY = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GUARD = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COMM = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_ASSIGN0 = 8'h10;
  localparam logic [ADDR_W-1:0] ASSIGN_STRIDE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h24;

  localparam logic [CODE_W-1:0] SEL_EXT_PANEL = 8'h00;
  localparam logic [CODE_W-1:0] SEL_PANEL = 8'h01;
  localparam logic [CODE_W-1:0] SEL_EXT = 8'h02;
  localparam logic [CODE_W-1:0] SEL_COMB1 = 8'h03;
  localparam logic [CODE_W-1:0] SEL_COMB2 = 8'h04;
  localparam logic [CODE_W-1:0] SEL_SWITCHOVER = 8'h06;
  localparam logic [CODE_W-1:0] SEL_INTERLOCK = 8'h07;

  localparam logic [CODE_W-1:0] FUNC_LOCKOUT = 8'h0c;
  localparam logic [CODE_W-1:0] FUNC_PANEL_EXT = 8'h10;
  localparam logic [CODE_W-1:0] FUNC_INHIBIT = 8'h18;
  localparam logic [CODE_W-1:0] FUNC_PANEL_NET = 8'h41;
  localparam logic [CODE_W-1:0] FUNC_EXT_NET = 8'h42;

  localparam logic [CODE_W-1:0] POL_INVERT = 8'h02;
  localparam logic [CODE_W-1:0] COMM_NET = 8'h01;
  localparam logic [CODE_W-1:0] COMM_PANEL_NET = 8'h0a;
  localparam logic [CODE_W-1:0] GUARD_LOCK = 8'h01;

  localparam logic [CODE_W-1:0] MODE_SEL_RST = 8'h00;
  localparam logic [CODE_W-1:0] PARAM_RST = 8'h00;
  localparam logic [CODE_W-1:0] ASSIGN_RST = 8'hff;

  typedef enum logic [1:0] {
    MODE_EXT = 2'b00,
    MODE_PANEL = 2'b01,
    MODE_NET = 2'b10,
    MODE_COMB = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_PANEL = 2'b01,
    SRC_NET = 2'b10,
    SRC_HELD = 2'b11
  } src_t;
endpackage

/* File: hw/opmode_if.sv */
// carrier between the selector core and its interlock and write-gate helpers
`timescale 1ns/1ps
interface opmode_if import opmode_pkg::*; #(parameter int N = NUM_TERM) ();
  logic [N-1:0] term;
  logic [CODE_W-1:0] func [N];
  logic [CODE_W-1:0] polarity;
  logic [CODE_W-1:0] mode_sel;
  logic [CODE_W-1:0] guard;
  logic [ADDR_W-1:0] wr_addr;
  logic lock_on;
  logic lock_used;
  logic lock_forced;
  logic inhibit_stop;
  logic pext_sw_asg;
  logic pext_sw;
  logic pnet_sw_asg;
  logic pnet_sw;
  logic enet_sw_asg;
  logic enet_sw;
  logic wr_allow;

  modport core (output term, func, polarity, mode_sel, guard, wr_addr,
    input lock_on, lock_used, lock_forced, inhibit_stop, pext_sw_asg, pext_sw,
    pnet_sw_asg, pnet_sw, enet_sw_asg, enet_sw, wr_allow);
  modport resolve (input term, func, polarity, mode_sel,
    output lock_on, lock_used, lock_forced, inhibit_stop, pext_sw_asg, pext_sw,
    pnet_sw_asg, pnet_sw, enet_sw_asg, enet_sw);
  modport gate (input guard, wr_addr, lock_forced, output wr_allow);
endinterface

/* File: hw/interlock_resolve.sv */
// terminal function decode and panel-lockout interlock level
`timescale 1ns/1ps
module interlock_resolve import opmode_pkg::*; #(
  parameter int N = NUM_TERM
) (
  opmode_if.resolve bus
);
  logic [N-1:0] hit_lock;
  logic [N-1:0] hit_inh;
  logic [N-1:0] hit_pext;
  logic [N-1:0] hit_pnet;
  logic [N-1:0] hit_enet;
  logic lock_asg;
  logic inh_asg;
  logic use_inh;
  logic raw;
  logic level;
  logic sel7;

  function automatic logic any_on(input logic [N-1:0] hit, input logic [N-1:0] t);
    any_on = |(hit & t);
  endfunction

  for (genvar i = 0; i < N; i++) begin : g_term
    assign hit_lock[i] = (bus.func[i] == FUNC_LOCKOUT);
    assign hit_inh[i] = (bus.func[i] == FUNC_INHIBIT);
    assign hit_pext[i] = (bus.func[i] == FUNC_PANEL_EXT);
    assign hit_pnet[i] = (bus.func[i] == FUNC_PANEL_NET);
    assign hit_enet[i] = (bus.func[i] == FUNC_EXT_NET);
  end

  always_comb begin
    sel7 = (bus.mode_sel == SEL_INTERLOCK);
    lock_asg = |hit_lock;
    inh_asg = |hit_inh;
    use_inh = !lock_asg && inh_asg;
    raw = lock_asg ? any_on(hit_lock, bus.term) : any_on(hit_inh, bus.term);
    level = (use_inh && bus.polarity == POL_INVERT) ? !raw : raw;
    bus.lock_used = sel7 && (lock_asg || inh_asg);
    bus.lock_on = bus.lock_used ? level : 1'b1;
    bus.lock_forced = bus.lock_used && !level;
    // inhibit input is an output stop again as soon as the setting leaves 7
    bus.inhibit_stop = inh_asg && !(sel7 && use_inh) && any_on(hit_inh, bus.term);
    bus.pext_sw_asg = |hit_pext;
    bus.pext_sw = any_on(hit_pext, bus.term);
    bus.pnet_sw_asg = |hit_pnet;
    bus.pnet_sw = any_on(hit_pnet, bus.term);
    bus.enet_sw_asg = |hit_enet;
    bus.enet_sw = any_on(hit_enet, bus.term);
  end
endmodule

/* File: hw/write_gate.sv */
// parameter write permission under interlock and write guard
`timescale 1ns/1ps
module write_gate import opmode_pkg::*; (
  opmode_if.gate bus
);
  always_comb begin
    bus.wr_allow = 1'b1;
    if (bus.wr_addr == REG_MODE_SEL) begin
      bus.wr_allow = 1'b1;
    end else if (bus.lock_forced) begin
      bus.wr_allow = 1'b0;
    end else if (bus.wr_addr == REG_GUARD) begin
      bus.wr_allow = 1'b1;
    end else if (bus.guard == GUARD_LOCK) begin
      bus.wr_allow = 1'b0;
    end
  end
endmodule

/* File: hw/operation_mode_selector.sv */
// operation mode selector: mode state, command sources, interlock, settings port
`timescale 1ns/1ps
module operation_mode_selector import opmode_pkg::*; #(
  parameter int N = NUM_TERM,
  parameter int SW = SPD_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [N-1:0] term_i,
  input wire logic forward_run_input_i,
  input wire logic reverse_run_input_i,
  input wire logic [SW-1:0] ext_speed_i,
  input wire logic [SW-1:0] panel_speed_i,
  input wire logic [SW-1:0] net_speed_i,
  input wire logic panel_rev_i,
  input wire logic net_rev_i,
  input wire logic panel_run_i,
  input wire logic net_run_i,
  input wire logic panel_mode_key_i,
  input wire logic panel_ext_key_i,
  input wire logic panel_stop_reset_key_i,
  input wire logic net_cmd_net_i,
  input wire logic net_cmd_ext_i,
  input wire logic running_i,
  input wire logic fault_i,
  output logic [1:0] op_mode_o,
  output logic run_o,
  output logic rev_o,
  output logic [SW-1:0] speed_o,
  output logic output_stop_o,
  output logic forced_ext_o,
  output logic unit_reset_o
);
  opmode_if #(.N(N)) bus ();

  logic [CODE_W-1:0] mode_sel_r, mode_sel_nxt;
  logic [CODE_W-1:0] polarity_r, polarity_nxt;
  logic [CODE_W-1:0] guard_r, guard_nxt;
  logic [CODE_W-1:0] comm_r, comm_nxt;
  logic [CODE_W-1:0] assign_r [N];
  logic [CODE_W-1:0] assign_nxt [N];
  logic [DATA_W-1:0] rdata_r, rdata_nxt;

  mode_t mode_r, mode_nxt;
  src_t dir_src_r, dir_src_nxt;
  src_t spd_src_r, spd_src_nxt;
  logic [SW-1:0] held_speed_r, held_speed_nxt;
  logic held_rev_r, held_rev_nxt;
  logic forced_r, forced_nxt;
  logic init_r, init_nxt;

  logic run_r, run_nxt;
  logic rev_r, rev_nxt;
  logic [SW-1:0] speed_r, speed_nxt;
  logic stop_r, stop_nxt;
  logic reset_r, reset_nxt;

  mode_t want;
  logic fixed;
  logic forced;
  logic refuse;
  logic accept;
  logic ext_rev;
  logic ext_run;
  logic can_switch;

  function automatic logic [ADDR_W-1:0] assign_addr(input int k);
    assign_addr = REG_ASSIGN0 + ADDR_W'(k) * ASSIGN_STRIDE;
  endfunction

  assign bus.term = term_i;
  assign bus.polarity = polarity_r;
  assign bus.mode_sel = mode_sel_r;
  assign bus.guard = guard_r;
  assign bus.wr_addr = addr_i;
  for (genvar i = 0; i < N; i++) begin : g_func
    assign bus.func[i] = assign_r[i];
  end

  interlock_resolve #(.N(N)) u_resolve (
    .bus(bus)
  );

  write_gate u_gate (
    .bus(bus)
  );

  // settings port
  always_comb begin
    mode_sel_nxt = mode_sel_r;
    polarity_nxt = polarity_r;
    guard_nxt = guard_r;
    comm_nxt = comm_r;
    assign_nxt = assign_r;
    rdata_nxt = '0;
    if (we_i && bus.wr_allow) begin
      if (addr_i == REG_MODE_SEL) begin
        mode_sel_nxt = wdata_i;
      end else if (addr_i == REG_POLARITY) begin
        polarity_nxt = wdata_i;
      end else if (addr_i == REG_GUARD) begin
        guard_nxt = wdata_i;
      end else if (addr_i == REG_COMM) begin
        comm_nxt = wdata_i;
      end else begin
        for (int k = 0; k < N; k++) begin
          if (addr_i == assign_addr(k)) begin
            assign_nxt[k] = wdata_i;
          end
        end
      end
    end
    if (re_i) begin
      if (addr_i == REG_MODE_SEL) begin
        rdata_nxt = mode_sel_r;
      end else if (addr_i == REG_POLARITY) begin
        rdata_nxt = polarity_r;
      end else if (addr_i == REG_GUARD) begin
        rdata_nxt = guard_r;
      end else if (addr_i == REG_COMM) begin
        rdata_nxt = comm_r;
      end else if (addr_i == REG_STATUS) begin
        rdata_nxt = {forced_r, bus.lock_on, spd_src_r, dir_src_r, mode_r};
      end else begin
        for (int k = 0; k < N; k++) begin
          if (addr_i == assign_addr(k)) begin
            rdata_nxt = assign_r[k];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_sel_r <= MODE_SEL_RST;
      polarity_r <= PARAM_RST;
      guard_r <= PARAM_RST;
      comm_r <= PARAM_RST;
      rdata_r <= '0;
      for (int k = 0; k < N; k++) begin
        assign_r[k] <= ASSIGN_RST;
      end
    end else if (ce_i) begin
      mode_sel_r <= mode_sel_nxt;
      polarity_r <= polarity_nxt;
      guard_r <= guard_nxt;
      comm_r <= comm_nxt;
      rdata_r <= rdata_nxt;
      assign_r <= assign_nxt;
    end
  end

  // mode request resolution, highest priority first
  always_comb begin
    want = mode_r;
    fixed = 1'b0;
    forced = 1'b0;
    if (mode_sel_r == SEL_PANEL) begin
      want = MODE_PANEL;
      fixed = 1'b1;
    end else if (mode_sel_r == SEL_COMB1 || mode_sel_r == SEL_COMB2) begin
      want = MODE_COMB;
      fixed = 1'b1;
    end else if (mode_sel_r == SEL_EXT) begin
      fixed = (mode_r != MODE_EXT && mode_r != MODE_NET);
      if (net_cmd_net_i || (bus.enet_sw_asg && bus.enet_sw)) begin
        want = MODE_NET;
      end else if (net_cmd_ext_i || fixed || bus.enet_sw_asg) begin
        want = MODE_EXT;
      end
    end else if (bus.lock_forced) begin
      want = MODE_EXT;
      forced = 1'b1;
    end else if (bus.enet_sw_asg && bus.enet_sw) begin
      want = MODE_NET;
    end else if (bus.pnet_sw_asg && comm_r == COMM_PANEL_NET) begin
      want = bus.pnet_sw ? MODE_PANEL : MODE_NET;
    end else if (bus.enet_sw_asg) begin
      want = MODE_EXT;
    end else if (bus.pext_sw_asg) begin
      want = bus.pext_sw ? MODE_EXT : MODE_PANEL;
    end else if (init_r) begin
      fixed = 1'b1;
      want = (comm_r == COMM_NET || comm_r == COMM_PANEL_NET) ? MODE_NET : MODE_EXT;
    end else if (net_cmd_net_i) begin
      want = MODE_NET;
    end else if (net_cmd_ext_i) begin
      want = MODE_EXT;
    end else if (panel_mode_key_i) begin
      want = MODE_PANEL;
    end else if (panel_ext_key_i) begin
      want = MODE_EXT;
    end
    ext_run = forward_run_input_i || reverse_run_input_i;
    // refusal only bites in interlock mode where the on state is meaningful
    refuse = (want == MODE_PANEL) && (mode_sel_r == SEL_INTERLOCK) && bus.lock_on && ext_run;
    can_switch = !running_i || (mode_sel_r == SEL_SWITCHOVER);
    accept = (want != mode_r) && (forced || fixed || can_switch) && !refuse;
  end

  // state update and source hand-over
  always_comb begin
    mode_nxt = mode_r;
    dir_src_nxt = dir_src_r;
    spd_src_nxt = spd_src_r;
    held_speed_nxt = held_speed_r;
    held_rev_nxt = held_rev_r;
    forced_nxt = bus.lock_forced;
    init_nxt = 1'b0;
    ext_rev = reverse_run_input_i && !forward_run_input_i;
    if (accept) begin
      mode_nxt = want;
      case (want)
        MODE_EXT: begin
          dir_src_nxt = SRC_EXT;
          spd_src_nxt = SRC_EXT;
        end
        MODE_PANEL: begin
          dir_src_nxt = SRC_PANEL;
          spd_src_nxt = SRC_PANEL;
          if (mode_sel_r == SEL_SWITCHOVER && mode_r == MODE_EXT) begin
            held_speed_nxt = ext_speed_i;
            held_rev_nxt = ext_rev;
            dir_src_nxt = SRC_HELD;
            spd_src_nxt = SRC_HELD;
          end else if (mode_sel_r == SEL_SWITCHOVER && mode_r == MODE_NET) begin
            // what network mode applied, which may itself be a retained value
            held_speed_nxt = speed_nxt;
            held_rev_nxt = rev_nxt;
            dir_src_nxt = SRC_HELD;
            spd_src_nxt = SRC_HELD;
          end
        end
        MODE_NET: begin
          dir_src_nxt = SRC_NET;
          spd_src_nxt = SRC_NET;
          if (mode_sel_r == SEL_SWITCHOVER && mode_r == MODE_EXT) begin
            held_speed_nxt = ext_speed_i;
            held_rev_nxt = ext_rev;
            dir_src_nxt = SRC_HELD;
            spd_src_nxt = SRC_HELD;
          end else if (mode_sel_r == SEL_SWITCHOVER && mode_r == MODE_PANEL) begin
            dir_src_nxt = dir_src_r;
            spd_src_nxt = spd_src_r;
          end
        end
        MODE_COMB: begin
          dir_src_nxt = (mode_sel_r == SEL_COMB2) ? SRC_PANEL : SRC_EXT;
          spd_src_nxt = (mode_sel_r == SEL_COMB2) ? SRC_EXT : SRC_PANEL;
        end
        default: begin
          mode_nxt = MODE_EXT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r <= MODE_EXT;
      dir_src_r <= SRC_EXT;
      spd_src_r <= SRC_EXT;
      held_speed_r <= '0;
      held_rev_r <= 1'b0;
      forced_r <= 1'b0;
      init_r <= 1'b1;
    end else if (ce_i) begin
      mode_r <= mode_nxt;
      dir_src_r <= dir_src_nxt;
      spd_src_r <= spd_src_nxt;
      held_speed_r <= held_speed_nxt;
      held_rev_r <= held_rev_nxt;
      forced_r <= forced_nxt;
      init_r <= init_nxt;
    end
  end

  // drive commands, registered so outputs come from flops
  always_comb begin
    case (mode_r)
      MODE_EXT: run_nxt = ext_run;
      MODE_PANEL: run_nxt = panel_run_i;
      MODE_NET: run_nxt = net_run_i;
      default: run_nxt = (mode_sel_r == SEL_COMB2) ? panel_run_i : ext_run;
    endcase
    case (dir_src_r)
      SRC_EXT: rev_nxt = ext_rev;
      SRC_PANEL: rev_nxt = panel_rev_i;
      SRC_NET: rev_nxt = net_rev_i;
      default: rev_nxt = held_rev_r;
    endcase
    case (spd_src_r)
      SRC_EXT: speed_nxt = ext_speed_i;
      SRC_PANEL: speed_nxt = panel_speed_i;
      SRC_NET: speed_nxt = net_speed_i;
      default: speed_nxt = held_speed_r;
    endcase
    // interlock on in external mode holds output off; off lets it run again
    stop_nxt = bus.inhibit_stop || (bus.lock_used && bus.lock_on && mode_r == MODE_EXT);
    if (stop_nxt) begin
      run_nxt = 1'b0;
    end
    reset_nxt = forced_r && fault_i && panel_stop_reset_key_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_r <= 1'b0;
      rev_r <= 1'b0;
      speed_r <= '0;
      stop_r <= 1'b0;
      reset_r <= 1'b0;
    end else if (ce_i) begin
      run_r <= run_nxt;
      rev_r <= rev_nxt;
      speed_r <= speed_nxt;
      stop_r <= stop_nxt;
      reset_r <= reset_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign op_mode_o = mode_r;
  assign run_o = run_r;
  assign rev_o = rev_r;
  assign speed_o = speed_r;
  assign output_stop_o = stop_r;
  assign forced_ext_o = forced_r;
  assign unit_reset_o = reset_r;
endmodule

/* File: tb/operation_mode_selector_properties.sv */
// concurrent checks on the operation mode selector ports
`timescale 1ns/1ps
module operation_mode_selector_properties import opmode_pkg::*; #(
  parameter int SW = SPD_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic forward_run_input_i,
  input wire logic reverse_run_input_i,
  input wire logic [SW-1:0] ext_speed_i,
  input wire logic panel_stop_reset_key_i,
  input wire logic running_i,
  input wire logic fault_i,
  input wire logic [1:0] op_mode_o,
  input wire logic run_o,
  input wire logic rev_o,
  input wire logic [SW-1:0] speed_o,
  input wire logic output_stop_o,
  input wire logic forced_ext_o,
  input wire logic unit_reset_o
);
  logic [CODE_W-1:0] sel_r;
  logic [CODE_W-1:0] sel_nxt;
  // mode select writes are never refused, so this shadow is exact
  always_comb begin
    sel_nxt = sel_r;
    if (ce_i && we_i && addr_i == REG_MODE_SEL) begin
      sel_nxt = wdata_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_r <= MODE_SEL_RST;
    end else begin
      sel_r <= sel_nxt;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_stop_no_run: assert property (output_stop_o |-> !run_o)
    else $error("run applied while output stopped");
  a_reset_cause: assert property (ce_i && forced_ext_o && fault_i && panel_stop_reset_key_i |=> unit_reset_o)
    else $error("unit reset missing after stop key");
  a_reset_only: assert property (unit_reset_o |-> $past(fault_i && panel_stop_reset_key_i))
    else $error("unit reset without fault and stop key");
  a_forced_ext: assert property (forced_ext_o ##1 forced_ext_o |-> op_mode_o == MODE_EXT)
    else $error("forced state not in external mode");
  a_comb_fixed: assert property ((ce_i && sel_r == SEL_COMB2) [*3] |-> op_mode_o == MODE_COMB)
    else $error("setting 4 left combined mode");
  a_comb_speed: assert property (ce_i && sel_r == SEL_COMB2 && op_mode_o == MODE_COMB
    |=> speed_o == $past(ext_speed_i))
    else $error("combined mode speed not external");
  a_ext_source: assert property ($past(rst_b_i) && ce_i && op_mode_o == MODE_EXT && sel_r != SEL_SWITCHOVER
    |=> rev_o == $past(reverse_run_input_i && !forward_run_input_i) && speed_o == $past(ext_speed_i))
    else $error("external mode sources wrong");
  a_hold_running: assert property (ce_i && running_i && sel_r == SEL_EXT_PANEL |=> $stable(op_mode_o))
    else $error("mode changed while running");
  a_freeze_all: assert property (!ce_i |=> $stable(op_mode_o) && $stable(speed_o) && $stable(rdata_o))
    else $error("state moved with clock enable low");
endmodule

/* File: tb/far_side_model.sv */
// operator panel, network link and terminal switches facing the selector
`timescale 1ns/1ps
module far_side_model import opmode_pkg::*; #(
  parameter logic [SPD_W-1:0] EXT_SPD = 16'h1234
) (
  input wire logic clk_i,
  output logic [4:0] key_o,
  output logic [NUM_TERM-1:0] term_o,
  output logic fwd_o,
  output logic rvs_o,
  output logic [SPD_W-1:0] ext_spd_o,
  output logic [SPD_W-1:0] pnl_spd_o,
  output logic [SPD_W-1:0] net_spd_o
);
  // key bits: panel key, ext key, stop/reset, to network, to external
  assign ext_spd_o = EXT_SPD;
  // other sources differ so a wrong pick shows
  assign pnl_spd_o = 16'h0abc;
  assign net_spd_o = 16'h0567;
  initial begin
    key_o = '0;
    term_o = '0;
    fwd_o = 1'b0;
    rvs_o = 1'b0;
  end
  // requests are one cycle; the selector does not queue them
  task automatic press(input int k);
    @(posedge clk_i);
    key_o[k] <= 1'b1;
    @(posedge clk_i);
    key_o[k] <= 1'b0;
  endtask
  task automatic levels(input logic [NUM_TERM-1:0] t, input logic f, input logic r);
    @(posedge clk_i);
    term_o <= t;
    fwd_o <= f;
    rvs_o <= r;
  endtask
endmodule

/* File: tb/operation_mode_selector_test.sv */
// self-checking bench for the operation mode selector
`timescale 1ns/1ps
module operation_mode_selector_test;
  import opmode_pkg::*;
  localparam logic [15:0] EXT_SPD = 16'h1234;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic running_i = 1'b0;
  logic fault_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic [4:0] key;
  logic [NUM_TERM-1:0] term;
  logic fwd;
  logic rvs;
  logic [SPD_W-1:0] ext_spd;
  logic [SPD_W-1:0] pnl_spd;
  logic [SPD_W-1:0] net_spd;
  logic [1:0] op_mode_o;
  logic run_o;
  logic rev_o;
  logic [SPD_W-1:0] speed_o;
  logic output_stop_o;
  logic forced_ext_o;
  logic unit_reset_o;
  int failures = 0;
  int compares = 0;
  int keys [6] = '{0, 3, 0, 1, 3, 4};
  logic [1:0] modes [6] = '{MODE_PANEL, MODE_NET, MODE_PANEL, MODE_EXT, MODE_NET, MODE_EXT};

  always #4 clk_i = ~clk_i;

  far_side_model #(.EXT_SPD(EXT_SPD)) u_far_side_model (.clk_i(clk_i), .key_o(key), .term_o(term),
    .fwd_o(fwd), .rvs_o(rvs), .ext_spd_o(ext_spd), .pnl_spd_o(pnl_spd), .net_spd_o(net_spd));

  operation_mode_selector u_operation_mode_selector (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .term_i(term),
    .forward_run_input_i(fwd), .reverse_run_input_i(rvs), .ext_speed_i(ext_spd), .panel_speed_i(pnl_spd),
    .net_speed_i(net_spd), .panel_rev_i(1'b0), .net_rev_i(1'b0), .panel_run_i(1'b1), .net_run_i(1'b1),
    .panel_mode_key_i(key[0]), .panel_ext_key_i(key[1]), .panel_stop_reset_key_i(key[2]),
    .net_cmd_net_i(key[3]), .net_cmd_ext_i(key[4]), .running_i(running_i), .fault_i(fault_i),
    .op_mode_o(op_mode_o), .run_o(run_o), .rev_o(rev_o), .speed_o(speed_o), .output_stop_o(output_stop_o),
    .forced_ext_o(forced_ext_o), .unit_reset_o(unit_reset_o));

  task automatic conclude();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    check(16'(rdata_o), 16'(exp));
  endtask

  // mode and source selection land one edge after the request, driven speed and direction one edge later
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic go(input int k, input logic [1:0] m);
    u_far_side_model.press(k);
    settle();
    check(16'(op_mode_o), 16'(m));
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    settle();
    check(16'(op_mode_o), 16'(MODE_EXT));
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4), (i >= 4) ? ASSIGN_RST : PARAM_RST);
    end
    rd(8'h28, 8'h00);
    u_far_side_model.levels('0, 1'b0, 1'b1);
    wr(REG_MODE_SEL, SEL_SWITCHOVER);
    rd(REG_MODE_SEL, SEL_SWITCHOVER);
    @(posedge clk_i);
    running_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      go(keys[i], modes[i]);
      check(speed_o, EXT_SPD);
      check(16'(rev_o), 16'h1);
    end
    wr(REG_MODE_SEL, SEL_EXT_PANEL);
    go(0, MODE_EXT);
    @(posedge clk_i);
    running_i <= 1'b0;
    wr(REG_MODE_SEL, SEL_COMB2);
    go(0, MODE_COMB);
    check(speed_o, EXT_SPD);
    check(16'(run_o), 16'h1);
    wr(REG_MODE_SEL, SEL_SWITCHOVER);
    go(0, MODE_PANEL);
    wr(REG_ASSIGN0, FUNC_LOCKOUT);
    u_far_side_model.levels(5'h01, 1'b0, 1'b0);
    wr(REG_MODE_SEL, SEL_INTERLOCK);
    settle();
    check(16'(op_mode_o), 16'(MODE_PANEL));
    u_far_side_model.levels(5'h00, 1'b0, 1'b0);
    settle();
    check(16'(forced_ext_o), 16'h1);
    go(0, MODE_EXT);
    wr(REG_GUARD, GUARD_LOCK);
    rd(REG_GUARD, PARAM_RST);
    @(posedge clk_i);
    fault_i <= 1'b1;
    u_far_side_model.press(2);
    #1;
    check(16'(unit_reset_o), 16'h1);
    fault_i <= 1'b0;
    u_far_side_model.levels(5'h01, 1'b1, 1'b0);
    settle();
    check(16'(output_stop_o), 16'h1);
    check(16'(run_o), 16'h0);
    go(0, MODE_EXT);
    u_far_side_model.levels(5'h01, 1'b0, 1'b0);
    wr(REG_MODE_SEL, SEL_EXT_PANEL);
    wr(REG_ASSIGN0, ASSIGN_RST);
    wr(8'(REG_ASSIGN0 + ASSIGN_STRIDE), FUNC_INHIBIT);
    wr(REG_POLARITY, POL_INVERT);
    rd(REG_POLARITY, POL_INVERT);
    wr(REG_MODE_SEL, SEL_INTERLOCK);
    u_far_side_model.levels(5'h02, 1'b0, 1'b0);
    settle();
    check(16'(forced_ext_o), 16'h1);
    u_far_side_model.levels(5'h00, 1'b0, 1'b0);
    settle();
    check(16'(forced_ext_o), 16'h0);
    // a panel request that would be taken, but the clock enable is low
    @(posedge clk_i);
    ce_i <= 1'b0;
    u_far_side_model.press(0);
    settle();
    check(16'(op_mode_o), 16'(MODE_EXT));
    ce_i <= 1'b1;
    wr(REG_MODE_SEL, SEL_EXT_PANEL);
    wr(8'(REG_ASSIGN0 + ASSIGN_STRIDE + ASSIGN_STRIDE), FUNC_PANEL_EXT);
    settle();
    check(16'(op_mode_o), 16'(MODE_PANEL));
    u_far_side_model.levels(5'h04, 1'b0, 1'b0);
    go(0, MODE_EXT);
    rd(REG_STATUS, 8'h40);
    conclude();
  end
endmodule

bind operation_mode_selector operation_mode_selector_properties #(.SW(SW)) u_props (.clk_i, .rst_b_i,
  .ce_i, .addr_i, .wdata_i, .we_i, .rdata_o, .forward_run_input_i, .reverse_run_input_i, .ext_speed_i,
  .panel_stop_reset_key_i, .running_i, .fault_i, .op_mode_o, .run_o, .rev_o, .speed_o, .output_stop_o,
  .forced_ext_o, .unit_reset_o);
